// ### core/rcw_pkg.sv
// Purpose: Constants and types of the runaway code watchdog
// Assumes: One 25 MHz clock, which is also the crystal clock
// Notes: Register offsets are word indices; byte address is four times
//
// Function
// R1 - 6-bit counter fed by 12-bit prescaler, crystal clock
// R2 - Overflow resets after short or long count
// R3 - Service write clears counter and prescaler stages 4-12
// R4 - Service read returns reset vector low byte
// R5 - Watchdog reset: pin low 32 cycles, cause set
// R6 - Monitor mode plus test voltage disables watchdog
// R7 - Break plus test voltage on reset pin disables
// R8 - Stop instruction clears the prescaler
// R9 - Power-on clears prescaler after 4096 cycles
// R10 - Internal reset clears prescaler and counter
// R11 - Reset vector fetch clears the prescaler
// R12 - Disable bit suppresses all watchdog resets
// R13 - No interrupt request, only reset
// R14 - Counting continues during wait mode
// R15 - Stop mode gates clock and clears prescaler
// R16 - Stop takes effect only with stop enable
// R17 - Long bit picks tap; overflow gives one request
package rcw_pkg;
   localparam int RCW_PRESCALE_BITS = 12;
   localparam int RCW_COUNT_BITS = 6;
   localparam int RCW_SHORT_TAP = 6;
   localparam int RCW_LONG_TAP = 11;
   localparam int RCW_SERVICE_CLEAR_LSB = 3;
   localparam int RCW_PIN_LOW_CYCLES = 32;
   localparam int RCW_POR_CLEAR_CYCLES = 4096;
   localparam logic [15:0] RCW_SERVICE_IDX = 16'hFFFF;
   localparam logic [15:0] RCW_CONFIG_IDX = 16'hFFF0;
   localparam logic [15:0] RCW_STATUS_IDX = 16'hFFF1;
   localparam int RCW_CFG_DISABLE_POS = 0;
   localparam int RCW_CFG_LONG_POS = 1;
   localparam int RCW_CFG_STOPEN_POS = 2;
   localparam int RCW_STS_CAUSE_POS = 0;
   localparam int RCW_STS_STOPPED_POS = 1;
   localparam int RCW_STS_DISABLED_POS = 2;
   localparam int RCW_STS_COUNT_LSB = 8;
   localparam logic [2:0] RCW_CONFIG_RESET = 3'h0;
   localparam logic [31:0] RCW_UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [1:0] {
      RCW_RUN = 2'b00,
      RCW_STOP = 2'b01,
      RCW_PULSE = 2'b10
   } rcw_phase_t;
endpackage

// ### core/rcw_reset_stretch.sv
// Purpose: Holds the reset pin low for a fixed number of cycles
// Assumes: start is a one-cycle pulse
// Notes: A start while busy is ignored
`timescale 1ns/1ns
module rcw_reset_stretch
   import rcw_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   output logic busy
);
   typedef struct packed {
      logic [5:0] count;
      logic busy;
   } rcw_stretch_t;

   rcw_stretch_t s;
   rcw_stretch_t next_s;

   always_comb begin
      next_s = s;
      if (s.busy) begin
         if (s.count == 6'(RCW_PIN_LOW_CYCLES - 1)) begin // see R5
            next_s.busy = 1'b0;
            next_s.count = 6'h0;
         end else begin
            next_s.count = s.count + 6'h1;
         end
      end else if (start) begin
         next_s.busy = 1'b1;
         next_s.count = 6'h0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.busy;

   property p_low_length;
      @(posedge clock) disable iff (rst)
      $fell(s.busy) |-> $past(s.count) == 6'(RCW_PIN_LOW_CYCLES - 1);
   endproperty
   a_low_length: assert property (p_low_length) // see R5
      else $error("Reset pin low time wrong");

   property p_start_low;
      @(posedge clock) disable iff (rst)
      (start && !s.busy) |=> s.busy && s.count == 6'h0;
   endproperty
   a_start_low: assert property (p_start_low) // see R5
      else $error("Reset pin not pulled low on start");
endmodule

// ### core/rcw_watchdog.sv
// Purpose: Runaway code watchdog with Avalon-MM register access
// Assumes: Crystal clock is the block clock; inputs synchronous
// Notes: Reset pin is open drain, only ever driven low
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
module rcw_watchdog
   import rcw_pkg::*;
#(
   parameter int PRESCALE_BITS = RCW_PRESCALE_BITS,
   parameter int COUNT_BITS = RCW_COUNT_BITS
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [17:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [7:0] resetVectorLow,
   input wire logic monitorMode,
   input wire logic breakState,
   input wire logic rstPinHighTestVolt,
   input wire logic irqPinHighTestVolt,
   input wire logic stopInstr,
   input wire logic stopExit,
   input wire logic vectorFetch,
   input wire logic internalReset,
   output logic chipResetReq,
   output logic rstPinOut,
   output logic rstPinOe
);
   typedef struct packed {
      rcw_phase_t phase;
      logic [PRESCALE_BITS-1:0] prescale;
      logic [COUNT_BITS-1:0] count;
      logic [12:0] porCount;
      logic porDone;
      logic cfgDisable;
      logic cfgLong;
      logic cfgStopEn;
      logic cause;
      logic ack;
      logic [31:0] readData;
      logic resetReq;
   } rcw_state_t;

   rcw_state_t s;
   rcw_state_t next_s;

   logic [15:0] regIdx;
   logic isService;
   logic isConfig;
   logic isStatus;
   logic wrTake;
   logic disabled;
   logic running;
   logic tick;
   logic overflow;
   logic pinBusy;
   logic [PRESCALE_BITS-1:0] tapMask;
   logic [PRESCALE_BITS-1:0] serviceMask;
   logic [31:0] statusWord;
   logic [31:0] readMux;

   assign regIdx = address[17:2];
   assign isService = regIdx == RCW_SERVICE_IDX;
   assign isConfig = regIdx == RCW_CONFIG_IDX;
   assign isStatus = regIdx == RCW_STATUS_IDX;
   // One wait state: request seen, answered on the following edge
   assign waitrequest = (read || write) && !s.ack;
   assign wrTake = write && s.ack;

   // Test voltage overrides only bite in monitor or break state
   assign disabled = s.cfgDisable // see R12
      || (monitorMode && (rstPinHighTestVolt || irqPinHighTestVolt)) // see R6
      || (breakState && rstPinHighTestVolt); // see R7

   // Wait mode is deliberately not an input: counting never pauses there
   assign running = (s.phase == RCW_RUN) && !disabled; // see R14

   // Long timeout needs 2^12 prescale per count, short needs 2^7
   assign tapMask = s.cfgLong // see R17
      ? PRESCALE_BITS'((1 << (RCW_LONG_TAP + 1)) - 1)
      : PRESCALE_BITS'((1 << (RCW_SHORT_TAP + 1)) - 1); // see R2
   assign tick = (s.prescale & tapMask) == tapMask;
   assign overflow = running && tick && (&s.count); // see R2

   // Stages 4 to 12 are bits 3 and up; the low stages keep running
   assign serviceMask = PRESCALE_BITS'((1 << RCW_SERVICE_CLEAR_LSB) - 1);

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[RCW_STS_CAUSE_POS] = s.cause;
      statusWord[RCW_STS_STOPPED_POS] = s.phase == RCW_STOP;
      statusWord[RCW_STS_DISABLED_POS] = disabled;
      statusWord[RCW_STS_COUNT_LSB +: COUNT_BITS] = s.count;
   end

   always_comb begin
      readMux = RCW_UNMAPPED_READ;
      if (isService) begin
         // Reads see the vector byte, never the watchdog state
         readMux = {24'h0000_00, resetVectorLow}; // see R4
      end else if (isConfig) begin
         readMux[RCW_CFG_DISABLE_POS] = s.cfgDisable;
         readMux[RCW_CFG_LONG_POS] = s.cfgLong;
         readMux[RCW_CFG_STOPEN_POS] = s.cfgStopEn;
      end else if (isStatus) begin
         readMux = statusWord;
      end
   end

   always_comb begin
      next_s = s;
      next_s.resetReq = 1'b0;
      next_s.ack = (read || write) && !s.ack;
      if (read && !s.ack) begin
         next_s.readData = readMux;
      end

      // Configuration bits, low byte lane only
      if (wrTake && isConfig && byteenable[0]) begin
         next_s.cfgDisable = writedata[RCW_CFG_DISABLE_POS];
         next_s.cfgLong = writedata[RCW_CFG_LONG_POS];
         next_s.cfgStopEn = writedata[RCW_CFG_STOPEN_POS];
      end

      // Cause bit is write-one-to-clear; a new overflow wins
      if (wrTake && isStatus && byteenable[0]
          && writedata[RCW_STS_CAUSE_POS]) begin
         next_s.cause = 1'b0;
      end

      if (running) begin
         next_s.prescale = s.prescale + 1'b1; // see R1
         if (tick) begin
            next_s.count = s.count + 1'b1; // see R1
         end
      end

      case (s.phase)
         RCW_RUN: begin
            if (overflow) begin
               next_s.resetReq = 1'b1; // see R17
               next_s.cause = 1'b1; // see R5
               next_s.phase = RCW_PULSE;
               next_s.prescale = '0;
               next_s.count = '0;
            end else if (stopInstr && s.cfgStopEn) begin // see R16
               next_s.phase = RCW_STOP;
               next_s.prescale = '0; // see R8
            end
         end
         RCW_STOP: begin
            // Clock to the chain is off; nothing advances here
            next_s.prescale = '0; // see R15
            if (stopExit) begin
               next_s.phase = RCW_RUN;
            end
         end
         RCW_PULSE: begin
            if (!pinBusy && !s.resetReq) begin
               next_s.phase = RCW_RUN;
            end
         end
         default: begin
            next_s.phase = RCW_RUN;
         end
      endcase

      if (vectorFetch) begin
         next_s.prescale = '0; // see R11
      end

      if (wrTake && isService && !overflow) begin
         next_s.count = '0; // see R3
         next_s.prescale = next_s.prescale & serviceMask; // see R3
      end

      if (!s.porDone) begin
         next_s.porCount = s.porCount + 13'h1;
         if (s.porCount == 13'(RCW_POR_CLEAR_CYCLES - 1)) begin
            next_s.porDone = 1'b1;
            next_s.prescale = '0; // see R9
         end
      end

      // Any other reset source of the chip restarts the chain
      if (internalReset) begin
         next_s.prescale = '0; // see R10
         next_s.count = '0; // see R10
         if (s.phase == RCW_STOP) begin
            next_s.phase = RCW_RUN;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.phase <= RCW_RUN;
         s.cfgDisable <= RCW_CONFIG_RESET[RCW_CFG_DISABLE_POS];
         s.cfgLong <= RCW_CONFIG_RESET[RCW_CFG_LONG_POS];
         s.cfgStopEn <= RCW_CONFIG_RESET[RCW_CFG_STOPEN_POS];
      end else begin
         s <= next_s;
      end
   end

   rcw_reset_stretch rcw_reset_stretch_inst (
      .clock(clock),
      .rst(rst),
      .start(s.resetReq),
      .busy(pinBusy)
   );

   assign readdata = s.readData;
   // Reset request is the only action; there is no interrupt output
   assign chipResetReq = s.resetReq; // see R13
   assign rstPinOut = 1'b0;
   assign rstPinOe = pinBusy; // see R5

   property p_disabled_quiet;
      @(posedge clock) disable iff (rst)
      disabled |=> !chipResetReq;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) // see R12
      else $error("Reset raised while watchdog disabled");

   property p_monitor_off;
      @(posedge clock) disable iff (rst)
      (monitorMode && irqPinHighTestVolt && s.phase == RCW_RUN)
         |=> s.count == $past(s.count) || s.count == '0;
   endproperty
   a_monitor_off: assert property (p_monitor_off) // see R6
      else $error("Counter advanced in monitor mode with test voltage");

   property p_break_off;
      @(posedge clock) disable iff (rst)
      (breakState && rstPinHighTestVolt) |-> !running;
   endproperty
   a_break_off: assert property (p_break_off) // see R7
      else $error("Watchdog running in break with test voltage");

   property p_service_clear;
      @(posedge clock) disable iff (rst)
      (write && !waitrequest && isService && !overflow)
         |=> s.count == '0 && s.prescale[PRESCALE_BITS-1:3] == '0;
   endproperty
   a_service_clear: assert property (p_service_clear) // see R3
      else $error("Service write did not clear the chain");

   property p_service_read;
      @(posedge clock) disable iff (rst)
      (read && !waitrequest && isService)
         |-> readdata == {24'h0000_00, $past(resetVectorLow)};
   endproperty
   a_service_read: assert property (p_service_read) // see R4
      else $error("Service read did not return vector byte");

   property p_overflow_pulse;
      @(posedge clock) disable iff (rst)
      chipResetReq |-> s.cause ##1 !chipResetReq ##1 rstPinOe;
   endproperty
   a_overflow_pulse: assert property (p_overflow_pulse) // see R17
      else $error("Overflow request not single or pin not pulled");

   property p_short_timeout;
      @(posedge clock) disable iff (rst)
      (running && !s.cfgLong && &s.count
         && s.prescale[RCW_SHORT_TAP:0] == 7'h7F)
         |=> chipResetReq;
   endproperty
   a_short_timeout: assert property (p_short_timeout) // see R2
      else $error("Short timeout overflow missed");

   property p_stop_enable;
      @(posedge clock) disable iff (rst)
      (stopInstr && !s.cfgStopEn && s.phase == RCW_RUN)
         |=> s.phase != RCW_STOP;
   endproperty
   a_stop_enable: assert property (p_stop_enable) // see R16
      else $error("Stop taken without stop enable");

   property p_stop_gated;
      @(posedge clock) disable iff (rst)
      (s.phase == RCW_STOP && !internalReset) |=> s.prescale == '0;
   endproperty
   a_stop_gated: assert property (p_stop_gated) // see R15
      else $error("Prescaler moved in stop mode");

   property p_fetch_clear;
      @(posedge clock) disable iff (rst)
      (vectorFetch && !(write && !waitrequest)) |=> s.prescale == '0;
   endproperty
   a_fetch_clear: assert property (p_fetch_clear) // see R11
      else $error("Vector fetch did not clear prescaler");

   property p_internal_clear;
      @(posedge clock) disable iff (rst)
      internalReset |=> s.prescale == '0 && s.count == '0;
   endproperty
   a_internal_clear: assert property (p_internal_clear) // see R10
      else $error("Internal reset did not clear the chain");

   property p_por_clear;
      @(posedge clock) disable iff (rst)
      (!s.porDone && s.porCount == 13'(RCW_POR_CLEAR_CYCLES - 1)
         && !internalReset) |=> s.porDone && s.prescale == '0;
   endproperty
   a_por_clear: assert property (p_por_clear) // see R9
      else $error("Power-on prescaler clear missed");

   property p_bus_answer;
      @(posedge clock) disable iff (rst)
      ((read || write) && waitrequest) |=> !waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("Bus request not answered in one wait state");

   property p_long_no_early;
      @(posedge clock) disable iff (rst)
      (s.cfgLong && !(&s.prescale)) |=> !chipResetReq;
   endproperty
   a_long_no_early: assert property (p_long_no_early) // see R17
      else $error("Long timeout overflowed before the last tap");

   property p_cause_set;
      @(posedge clock) disable iff (rst)
      overflow |=> s.cause && chipResetReq;
   endproperty
   a_cause_set: assert property (p_cause_set) // see R5
      else $error("Overflow did not set the cause bit");

   property p_disabled_frozen;
      @(posedge clock) disable iff (rst)
      (disabled && s.porDone && !internalReset && !wrTake
         && !vectorFetch && !stopInstr)
         |=> s.count == $past(s.count) && s.prescale == $past(s.prescale);
   endproperty
   a_disabled_frozen: assert property (p_disabled_frozen) // see R12
      else $error("Chain advanced while watchdog disabled");

   property p_stop_exit;
      @(posedge clock) disable iff (rst)
      (s.phase == RCW_STOP && stopExit) |=> s.phase == RCW_RUN;
   endproperty
   a_stop_exit: assert property (p_stop_exit) // see R15
      else $error("Stop mode not left on exit");
endmodule

// ### bench/runaway_code_watchdog_tb.sv
// Purpose: Self-checking bench for the runaway code watchdog
// Assumes: Short timeout keeps the run near 50k cycles
// Notes: Long timeout only checked for not firing early, 2^18 is too slow
`timescale 1ns/1ns
module runaway_code_watchdog_tb
   import rcw_pkg::*;
;
   logic clock;
   logic rst;
   logic [17:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic [7:0] resetVectorLow;
   logic monitorMode;
   logic breakState;
   logic rstPinHighTestVolt;
   logic irqPinHighTestVolt;
   logic stopInstr;
   logic stopExit;
   logic vectorFetch;
   logic internalReset;
   logic chipResetReq;
   logic rstPinOut;
   logic rstPinOe;
   int fails;
   int samplesChecked;
   int resetCount;
   int n;
   logic [31:0] rd;
   logic [5:0] c1;

   rcw_watchdog rcw_watchdog_inst (
      .clock(clock),
      .rst(rst),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(4'hF),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .resetVectorLow(resetVectorLow),
      .monitorMode(monitorMode),
      .breakState(breakState),
      .rstPinHighTestVolt(rstPinHighTestVolt),
      .irqPinHighTestVolt(irqPinHighTestVolt),
      .stopInstr(stopInstr),
      .stopExit(stopExit),
      .vectorFetch(vectorFetch),
      .internalReset(internalReset),
      .chipResetReq(chipResetReq),
      .rstPinOut(rstPinOut),
      .rstPinOe(rstPinOe)
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Counts overflow requests so every scenario can see stray resets
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         resetCount <= 0;
      end else if (chipResetReq === 1'b1) begin
         resetCount <= resetCount + 1;
      end
   end

   task automatic check_word(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_span(input string name, input int lo, input int hi,
         input int got);
      samplesChecked++;
      if (got < lo || got > hi) begin
         fails++;
         $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   // Request stands until waitrequest is sampled low at a rising edge;
   // read data is taken and the request dropped at that same edge
   task automatic bus_access(input logic isWrite, input logic [15:0] idx,
         input logic [31:0] data);
      int i;
      i = 0;
      @(posedge clock);
      address <= {idx, 2'b00};
      writedata <= data;
      read <= !isWrite;
      write <= isWrite;
      do begin
         @(posedge clock);
         i++;
      end while (waitrequest !== 1'b0 && i < 20);
      if (i >= 20) begin
         fails++;
         $display("FAIL waitrequest expected 0 seen %b", waitrequest);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic bus_write(input logic [15:0] idx, input logic [31:0] d);
      bus_access(1'b1, idx, d);
   endtask

   task automatic bus_read(input logic [15:0] idx);
      bus_access(1'b0, idx, 32'h0000_0000);
   endtask

   task automatic wait_cycles(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic pulse(input int which);
      @(posedge clock);
      case (which)
         0: stopInstr <= 1'b1;
         1: stopExit <= 1'b1;
         2: vectorFetch <= 1'b1;
         default: internalReset <= 1'b1;
      endcase
      @(posedge clock);
      stopInstr <= 1'b0;
      stopExit <= 1'b0;
      vectorFetch <= 1'b0;
      internalReset <= 1'b0;
   endtask

   task automatic report_and_stop();
      if (fails == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #(80000 * 40);
      fails++;
      $display("FAIL run time expected under 80000 cycles seen more");
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      writedata = '0;
      resetVectorLow = 8'hA5;
      {monitorMode, breakState} = 2'b00;
      {rstPinHighTestVolt, irqPinHighTestVolt} = 2'b00;
      {stopInstr, stopExit, vectorFetch, internalReset} = 4'h0;
      fails = 0;
      samplesChecked = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      bus_read(RCW_CONFIG_IDX);
      check_word("config reset", 32'h0000_0000, rd & 32'h0000_0007);
      bus_read(RCW_STATUS_IDX);
      check_word("status reset", 32'h0000_0000, rd & 32'h0000_0007);
      bus_write(16'h0010, 32'hFFFF_FFFF);
      bus_read(16'h0010);
      check_word("unmapped read", RCW_UNMAPPED_READ, rd);
      bus_read(RCW_SERVICE_IDX);
      check_word("service read", 32'h0000_00A5, rd);
      resetVectorLow <= 8'h3C;
      bus_read(RCW_SERVICE_IDX);
      check_word("service read", 32'h0000_003C, rd);
      // Disabled early, before the first short timeout can run out
      bus_write(RCW_CONFIG_IDX, 32'h0000_0001);
      wait_cycles(9000);
      bus_read(RCW_STATUS_IDX);
      check_word("disabled flag", 32'h0000_0004, rd & 32'h0000_0007);
      check_word("resets while off", 32'h0000_0000, resetCount);
      bus_write(RCW_CONFIG_IDX, 32'h0000_0000);
      bus_write(RCW_SERVICE_IDX, 32'h0000_0055);
      n = 0;
      while (chipResetReq !== 1'b1 && n < 9000) begin
         @(negedge clock);
         n++;
      end
      check_span("short timeout", 8150, 8210, n);
      n = 0;
      repeat (40) begin
         @(negedge clock);
         if (rstPinOe === 1'b1) n++;
      end
      check_span("pin low cycles", 32, 32, n);
      check_word("pin level", 32'h0000_0000, {31'h0, rstPinOut});
      check_word("reset requests", 32'h0000_0001, resetCount);
      bus_read(RCW_STATUS_IDX);
      check_word("cause set", 32'h0000_0001, rd & 32'h0000_0001);
      bus_write(RCW_STATUS_IDX, 32'h0000_0001);
      bus_read(RCW_STATUS_IDX);
      check_word("cause cleared", 32'h0000_0000, rd & 32'h0000_0001);
      bus_write(RCW_CONFIG_IDX, 32'h0000_0002);
      bus_write(RCW_SERVICE_IDX, 32'h0000_0000);
      wait_cycles(9000);
      check_word("long no reset", 32'h0000_0001, resetCount);
      bus_write(RCW_CONFIG_IDX, 32'h0000_0000);
      repeat (3) begin
         bus_write(RCW_SERVICE_IDX, 32'h0000_0000);
         wait_cycles(6000);
      end
      bus_write(RCW_SERVICE_IDX, 32'h0000_0000);
      bus_read(RCW_STATUS_IDX);
      check_word("count cleared", 32'h0000_0000, rd & 32'h0000_3F00);
      check_word("serviced no reset", 32'h0000_0001, resetCount);
      bus_write(RCW_CONFIG_IDX, 32'h0000_0002);
      for (int i = 0; i < 16; i++) begin
         logic e;
         e = (i[3] & (i[1] | i[0])) | (i[2] & i[1]);
         @(posedge clock);
         {monitorMode, breakState} <= 2'(i >> 2);
         {rstPinHighTestVolt, irqPinHighTestVolt} <= 2'(i);
         wait_cycles(3);
         bus_read(RCW_STATUS_IDX);
         check_word("mode disable", {29'h0, e, 2'b00}, rd & 32'h4);
      end
      {monitorMode, breakState} <= 2'b00;
      {rstPinHighTestVolt, irqPinHighTestVolt} <= 2'b00;
      bus_write(RCW_CONFIG_IDX, 32'h0000_0000);
      bus_write(RCW_SERVICE_IDX, 32'h0000_0000);
      pulse(0);
      bus_read(RCW_STATUS_IDX);
      check_word("stop refused", 32'h0000_0000, rd & 32'h0000_0002);
      bus_write(RCW_CONFIG_IDX, 32'h0000_0004);
      bus_write(RCW_SERVICE_IDX, 32'h0000_0000);
      wait_cycles(300);
      pulse(0);
      bus_read(RCW_STATUS_IDX);
      check_word("stopped", 32'h0000_0002, rd & 32'h0000_0002);
      c1 = rd[13:8];
      wait_cycles(600);
      bus_read(RCW_STATUS_IDX);
      check_word("count frozen", {26'h0, c1}, {26'h0, rd[13:8]});
      pulse(1);
      wait_cycles(600);
      bus_read(RCW_STATUS_IDX);
      check_word("stop left", 32'h0000_0000, rd & 32'h0000_0002);
      check_word("count runs", 32'h1, {31'h0, rd[13:8] != c1});
      bus_write(RCW_SERVICE_IDX, 32'h0000_0000);
      wait_cycles(700);
      pulse(2);
      bus_read(RCW_STATUS_IDX);
      check_word("fetch keeps count", 32'h1, {31'h0, rd[13:8] != 0});
      // A cleared prescaler needs 128 cycles before the next count
      c1 = rd[13:8];
      wait_cycles(100);
      bus_read(RCW_STATUS_IDX);
      check_word("fetch tick", {26'h0, c1}, {26'h0, rd[13:8]});
      pulse(3);
      bus_read(RCW_STATUS_IDX);
      check_word("count after reset", 32'h0, {26'h0, rd[13:8]});
      check_word("no extra resets", 32'h0000_0001, resetCount);
      report_and_stop();
   end
endmodule
